// ==== src/owp_formatter.sv ====
// Output-word formatter: config register, test patterns and parity append
`timescale 1ns/1ps
module owp_formatter
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire owp_pkg::owp_req_s req_i,
   input wire logic req_valid_i,
   output logic [7:0] rdata_o,
   output owp_pkg::owp_cfg_s cfg_o,
   input wire logic [15:0] conv_data_i,
   input wire logic conv_valid_i,
   output logic [19:0] word_o,
   output logic word_valid_o
);
   owp_pkg::owp_state_s state;
   owp_pkg::owp_state_s next_state;
   owp_pkg::owp_cfg_s cfg;
   logic [15:0] upper;
   logic full_par;
   logic part_par;
   logic hit;

   // Field view of the stored register
   assign cfg.partial_parity_span =
      state.cfg[owp_pkg::SPAN_LSB +: 2];
   assign cfg.parity_append_enable = state.cfg[owp_pkg::PAREN_BIT];
   assign cfg.output_pattern_select =
      state.cfg[owp_pkg::PATN_LSB +: 3];
   assign hit = req_i.addr == owp_pkg::CFG_ADDR;

   // Upper field source; low select bits ignored for live data
   always_comb
   begin
      case (cfg.output_pattern_select)
         owp_pkg::SEL_ZEROS: upper = owp_pkg::PATN_ZEROS;
         owp_pkg::SEL_ONES: upper = owp_pkg::PATN_ONES;
         owp_pkg::SEL_ALT1: upper = owp_pkg::PATN_ALT1;
         owp_pkg::SEL_ALT2: upper = owp_pkg::PATN_ALT2;
         default: upper = conv_data_i;
      endcase
   end

   owp_parity #(.WIDTH(16)) u_par
   (
      .bits_i(upper),
      .span_i(cfg.partial_parity_span),
      .full_o(full_par),
      .partial_o(part_par)
   );

   // Next state: register writes and word assembly
   always_comb
   begin
      next_state = state;
      next_state.word_valid = 1'b0;
      if (req_valid_i && req_i.wr && hit)
      begin
         // Reserved bits masked off so they can never be set
         next_state.cfg = req_i.wdata & owp_pkg::CFG_WMASK;
      end
      if (conv_valid_i)
      begin
         next_state.word[19:4] = upper;
         // A write in the same cycle only affects later conversions
         if (cfg.parity_append_enable)
         begin
            next_state.word[3] = full_par;
            next_state.word[2] = part_par;
         end
         else
         begin
            // Both parity slots held at zero so the host sees no stale bits
            next_state.word[3:2] = 2'h0;
         end
         next_state.word[1:0] = 2'h0;
         next_state.word_valid = 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (sys_rst_i)
      begin
         state.cfg <= owp_pkg::CFG_RESET;
         state.word <= 20'h00000;
         state.word_valid <= 1'b0;
      end
      else
      begin
         state <= next_state;
      end
   end

   // Unmapped addresses read zero; register read is combinational
   assign rdata_o = hit ? state.cfg : 8'h00;
   assign cfg_o = cfg;
   assign word_o = state.word;
   assign word_valid_o = state.word_valid;

   // Word checks look one cycle after each conversion; the antecedent
   // samples the config in force at the conversion edge, which is the
   // one the word was built from even when a write lands in that cycle.

   // Reserved bits are masked on write, so they must never be stored
   chk_resv_zero: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      state.cfg[7:6] == 2'h0)
      else $error("reserved config bits set");

   // A write to the mapped address lands at the next edge
   chk_cfg_write: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      req_valid_i && req_i.wr && req_i.addr == 10'h01C
      |=> state.cfg[5:0] == $past(req_i.wdata[5:0]))
      else $error("config write lost");

   // Writes elsewhere and idle cycles leave the register alone
   chk_cfg_hold: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !(req_valid_i && req_i.wr && req_i.addr == 10'h01C)
      |=> $stable(state.cfg))
      else $error("config changed without a write");

   // Parity off: both parity slots carry zero
   chk_par_off: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && !cfg.parity_append_enable
      |=> word_o[3:2] == 2'h0)
      else $error("parity bits not zero when disabled");

   // Full parity recomputed from the word as it leaves
   chk_full_par: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.parity_append_enable
      |=> word_o[3] == ^word_o[19:4])
      else $error("full parity wrong");

   // Partial parity, one check per short span
   chk_part_four: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.parity_append_enable
      && cfg.partial_parity_span == owp_pkg::SPAN_4
      |=> word_o[2] == ^word_o[19:16])
      else $error("partial parity over 4 bits wrong");
   chk_part_par: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.parity_append_enable
      && cfg.partial_parity_span == owp_pkg::SPAN_8
      |=> word_o[2] == ^word_o[19:12])
      else $error("partial parity wrong");
   chk_part_twelve: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.parity_append_enable
      && cfg.partial_parity_span == owp_pkg::SPAN_12
      |=> word_o[2] == ^word_o[19:8])
      else $error("partial parity over 12 bits wrong");

   // Widest span: partial parity equals the full parity
   chk_span_all: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.partial_parity_span == owp_pkg::SPAN_16
      |=> word_o[2] == word_o[3])
      else $error("span 16 parity differs from full");

   // Live data passes untouched whatever the low select bits hold
   chk_live_data: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && !cfg.output_pattern_select[2]
      |=> word_o[19:4] == $past(conv_data_i))
      else $error("conversion data not passed");

   // Fixed patterns replace the conversion data entirely
   chk_pat_zeros: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.output_pattern_select == owp_pkg::SEL_ZEROS
      |=> word_o[19:4] == 16'h0000)
      else $error("all zeros pattern wrong");
   chk_pat_ones: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.output_pattern_select == owp_pkg::SEL_ONES
      |=> word_o[19:4] == 16'hFFFF)
      else $error("all ones pattern wrong");
   chk_alt_pat: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.output_pattern_select == owp_pkg::SEL_ALT1
      |=> word_o[19:4] == 16'h5555)
      else $error("alternating pattern wrong");
   chk_pair_pat: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i && cfg.output_pattern_select == owp_pkg::SEL_ALT2
      |=> word_o[19:4] == 16'h3333)
      else $error("bit-pair pattern wrong");

   // One word per conversion, one cycle later, for exactly one cycle
   chk_word_pulse: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      conv_valid_i
      |=> word_valid_o)
      else $error("word missing after conversion");
   chk_no_word: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !conv_valid_i
      |=> !word_valid_o)
      else $error("word without conversion");

   // Between conversions the word stays put so a slow host can read it
   chk_word_hold: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      !conv_valid_i
      |=> $stable(word_o))
      else $error("word changed without conversion");

   // Unused low bits always zero
   chk_low_zero: assert property (
      @(posedge clk_i) disable iff (sys_rst_i)
      word_valid_o |-> word_o[1:0] == 2'h0)
      else $error("low word bits not zero");
endmodule : owp_formatter

// ==== src/owp_pkg.sv ====
// Package for the output-word formatter: register map, fields, patterns
package owp_pkg;
   localparam logic [9:0] CFG_ADDR = 10'h01C;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_WMASK = 8'h3F;
   localparam int SPAN_LSB = 4;
   localparam int PAREN_BIT = 3;
   localparam int PATN_LSB = 0;
   localparam logic [15:0] PATN_ZEROS = 16'h0000;
   localparam logic [15:0] PATN_ONES = 16'hFFFF;
   localparam logic [15:0] PATN_ALT1 = 16'h5555;
   localparam logic [15:0] PATN_ALT2 = 16'h3333;
   localparam logic [1:0] SPAN_4 = 2'h0;
   localparam logic [1:0] SPAN_8 = 2'h1;
   localparam logic [1:0] SPAN_12 = 2'h2;
   localparam logic [1:0] SPAN_16 = 2'h3;
   localparam logic [2:0] SEL_ZEROS = 3'h4;
   localparam logic [2:0] SEL_ONES = 3'h5;
   localparam logic [2:0] SEL_ALT1 = 3'h6;
   localparam logic [2:0] SEL_ALT2 = 3'h7;

   // Decoded configuration fields
   typedef struct packed {
      logic [1:0] partial_parity_span;
      logic parity_append_enable;
      logic [2:0] output_pattern_select;
   } owp_cfg_s;

   // Register write/read request from the serial front end
   typedef struct packed {
      logic wr;
      logic [9:0] addr;
      logic [7:0] wdata;
   } owp_req_s;

   // Whole state of the formatter
   typedef struct packed {
      logic [7:0] cfg;
      logic [19:0] word;
      logic word_valid;
   } owp_state_s;
endpackage : owp_pkg

// ==== src/owp_parity.sv ====
// Even-parity generator over the top bits of the 16-bit upper field
`timescale 1ns/1ps
module owp_parity
#(
   parameter int WIDTH = 16
)
(
   input wire logic [WIDTH-1:0] bits_i,
   input wire logic [1:0] span_i,
   output logic full_o,
   output logic partial_o
);
   // Spans are nibble multiples, counted from the MSB
   always_comb
   begin
      full_o = ^bits_i;
      case (span_i)
         owp_pkg::SPAN_4: partial_o = ^bits_i[WIDTH-1 -: 4];
         owp_pkg::SPAN_8: partial_o = ^bits_i[WIDTH-1 -: 8];
         owp_pkg::SPAN_12: partial_o = ^bits_i[WIDTH-1 -: 12];
         default: partial_o = ^bits_i;
      endcase
   end
endmodule : owp_parity

// ==== bench/owp_host.sv ====
// Host model that collects formatted words from the formatter
`timescale 1ns/1ps
module owp_host
(
   input wire logic clk_i,
   input wire logic [19:0] word_i,
   input wire logic word_valid_i
);
   logic [19:0] words[$];
   // A word is flagged valid for one cycle only, so take it at that edge
   always @(posedge clk_i)
   begin
      if (word_valid_i === 1'b1)
         words.push_back(word_i);
   end
endmodule : owp_host

// ==== bench/tb_top.sv ====
// Self-checking bench for the output-word formatter
`timescale 1ns/1ps
module tb_top;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   owp_pkg::owp_req_s req_i = '0;
   logic req_valid_i = 1'b0;
   logic [7:0] rdata_o;
   owp_pkg::owp_cfg_s cfg_o;
   logic [15:0] conv_data_i = 16'h0000;
   logic conv_valid_i = 1'b0;
   logic [19:0] word_o;
   logic word_valid_o;
   int num_errors = 0;
   int compares = 0;
   logic [19:0] exp_q[$];
   logic [19:0] got_w;
   logic [19:0] exp_w;
   // Free-running 250 MHz clock
   initial forever #2 clk_i = ~clk_i;
   owp_formatter owp_formatter_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .req_i(req_i), .req_valid_i(req_valid_i), .rdata_o(rdata_o),
      .cfg_o(cfg_o), .conv_data_i(conv_data_i), .conv_valid_i(conv_valid_i),
      .word_o(word_o), .word_valid_o(word_valid_o));
   owp_host owp_host_inst (.clk_i(clk_i), .word_i(word_o),
      .word_valid_i(word_valid_o));
   task check(input logic [19:0] got, input logic [19:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask : check
   // Expected word from config and data, built from plain integers
   function automatic logic [19:0] model(input int c, input int v);
      int up;
      int n;
      int f;
      int p;
      case (c[2:0])
         3'h4: up = 32'h00000000;
         3'h5: up = 32'h0000FFFF;
         3'h6: up = 32'h00005555;
         3'h7: up = 32'h00003333;
         default: up = v;
      endcase
      n = 4 * (((c >> 4) & 3) + 1);
      f = c[3] ? ^up : 0;
      p = c[3] ? ^(up >> (16 - n)) : 0;
      return {up[15:0], f[0], p[0], 2'b00};
   endfunction : model
   task wr(input logic [9:0] a, input logic [7:0] v);
      @(negedge clk_i);
      req_i = '{1'b1, a, v};
      req_valid_i = 1'b1;
      @(negedge clk_i);
      req_valid_i = 1'b0;
   endtask : wr
   task rd(input logic [9:0] a, input logic [7:0] v);
      @(negedge clk_i);
      req_i = '{1'b0, a, 8'h00};
      #1 check({12'h000, rdata_o}, {12'h000, v});
   endtask : rd
   task summarize;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // Sweep every config byte, with two back-to-back random conversions each
   initial
   begin
      void'($urandom(32'hEF0A67B1));
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      rd(10'h01C, 8'h00);
      for (int c = 0; c < 256; c++)
      begin
         wr(10'h01C, c[7:0]);
         wr(10'h01D, ~c[7:0]);
         rd(10'h01C, c[7:0] & 8'h3F);
         rd(10'h01D, 8'h00);
         check({14'h0000, cfg_o}, {14'h0000, c[5:0]});
         repeat (2)
         begin
            @(negedge clk_i);
            conv_data_i = 16'($urandom);
            conv_valid_i = 1'b1;
            exp_q.push_back(model(c, int'(conv_data_i)));
         end
         @(negedge clk_i);
         conv_valid_i = 1'b0;
         @(negedge clk_i);
         while (owp_host_inst.words.size() > 0 && exp_q.size() > 0)
         begin
            got_w = owp_host_inst.words.pop_front();
            exp_w = exp_q.pop_front();
            check(got_w, exp_w);
            check({18'h00000, got_w[1:0]}, 20'h00000);
         end
         check(20'(exp_q.size()), 20'h00000);
         check(20'(owp_host_inst.words.size()), 20'h00000);
      end
      $display("config sweep finished");
      // Mid-run reset: register back to default, and a conversion that
      // arrives while reset is high must not produce a word
      wr(10'h01C, 8'h3F);
      @(negedge clk_i);
      conv_data_i = 16'($urandom);
      conv_valid_i = 1'b1;
      sys_rst_i = 1'b1;
      @(negedge clk_i);
      conv_valid_i = 1'b0;
      repeat (3) @(negedge clk_i);
      sys_rst_i = 1'b0;
      rd(10'h01C, 8'h00);
      check(word_o, 20'h00000);
      check(20'(owp_host_inst.words.size()), 20'h00000);
      $display("reset test finished");
      summarize();
   end
   // Watchdog: sweep and reset test need about 2600 cycles
   initial
   begin
      #40000;
      num_errors++;
      summarize();
   end
endmodule : tb_top
